//--- codec_model.sv
// codec model: drives the link clock, frame sync and serial data, captures returned bits
`timescale 1ns/1ps
`default_nettype none

module codec_model (
    input wire logic run,
    input wire logic [8:0] len,
    input wire logic [255:0] fb,
    input wire logic [255:0] fs,
    input wire logic sdata_out,
    output logic bit_clk,
    output logic frame_sync,
    output logic sdata_in,
    output logic [255:0] ob
);
    logic [8:0] cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // link clock stands still while idle; the data line then toggles so no stale bit is seen
    initial begin
        bit_clk = 1'b0;
        frame_sync = 1'b0;
        sdata_in = 1'b0;
        ob = '0;
        cnt = 9'h000;
        #3;
        forever begin
            #62.5;
            if (run) begin
                bit_clk = ~bit_clk;
            end else begin
                sdata_in = ~sdata_in;
            end
        end
    end

    always @(negedge bit_clk) begin
        cnt = (cnt >= len - 9'h001) ? 9'h000 : cnt + 9'h001;
        sdata_in = fb[cnt];
        frame_sync = fs[cnt];
    end

    // capture indexed by the bit position of the preceding falling edge
    always @(posedge bit_clk) begin
        ob[cnt] = sdata_out;
    end
endmodule
`default_nettype wire

//--- sample_fifo.sv
// file: small synchronous sample queue with array storage
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
    parameter int W = 20,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic push,
    input wire logic [W-1:0] push_data,
    input wire logic pop,
    output logic [W-1:0] head,
    output logic full,
    output logic empty,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    wire do_push = ce && push && !full;
    wire do_pop = ce && pop && !empty;

    // pointers carry one extra wrap bit so full and empty are exact
    assign level = wr_ptr_r - rd_ptr_r;
    assign full = (level == (AW+1)'(DEPTH));
    assign empty = (level == '0);
    assign head = mem[rd_ptr_r[AW-1:0]];

    // storage is not reset; only the pointers carry state
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr_r[AW-1:0]] <= push_data;
        end
    end

    // pointer advance
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

//--- sau_pkg.sv
// package: register map, field positions, reset values and link constants of the audio channel
package sau_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets, one aligned word each
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_TX_FIRST = 8'h0C;
    localparam logic [7:0] OFF_TX_SECOND = 8'h10;
    localparam logic [7:0] OFF_RX_FIRST = 8'h14;
    localparam logic [7:0] OFF_RX_SECOND = 8'h18;
    localparam logic [7:0] OFF_LEVELS = 8'h1C;

    ////////////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int CTRL_W = 6;
    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_RX_EN = 1;
    localparam int CTRL_AC97 = 2;
    localparam int CTRL_DUAL_CHANNEL_ENABLE = 3;
    localparam int CTRL_FIRST_FIFO_ENABLE = 4;
    localparam int CTRL_SECOND_FIFO_ENABLE = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    // status and mask fields, same layout
    localparam int STAT_W = 3;
    localparam int STAT_TX_UNDERRUN = 0;
    localparam int STAT_RX_OVERRUN = 1;
    localparam int STAT_CLOCK_RATIO = 2;
    localparam logic [STAT_W-1:0] STAT_RESET = 3'h0;
    localparam logic [STAT_W-1:0] MASK_RESET = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // link framing
    localparam int SLOT_W = 20;
    localparam int I2S_WORD_BITS = 16;
    localparam logic [4:0] AC97_TAG_BITS = 5'h10;
    localparam logic [4:0] AC97_DATA_BITS = 5'h14;
    localparam logic [4:0] I2S_BITS = 5'h10;
    localparam logic [3:0] AC97_SLOT_LEFT = 4'h3;
    localparam logic [3:0] AC97_SLOT_RIGHT = 4'h4;
    localparam int TAG_FRAME_VALID = 15;
    localparam logic [15:0] TX_TAG = 16'h9800;
    // fewest core cycles in half a link clock period for a clean slot-ignore crossing
    localparam logic [7:0] SYNC_MIN_CYCLES = 8'h04;

endpackage

//--- serial_audio_unit.sv
// file: serial audio channel with I2S and AC97 framing, sample queues and register port
//
// Contract
// - AC97 16-bit receive samples land in bits 19..4 of the queue entry.
// - Slot-ignore may drop one cycle; crossing needs 4 core cycles per half period.
// - Single-queue I2S stores and sends left then right, alternating.
// - Single-queue underrun repeats the previous sample on both slots.
// - Single-queue data arriving at a right slot goes out there, swapping order.
// - Single-queue overrun emptied during a right slot swaps stored channels.
// - Dual queues: left transmit from first queue, right from second.
// - Dual underrun repeats each channel's own previous sample.
// - Dual queues: left received into first queue, right into second.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module serial_audio_unit #(
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    input wire logic bit_clk,
    input wire logic frame_sync,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic irq
);
    localparam int LW = $clog2(DEPTH) + 1;
    localparam int SW = sau_pkg::SLOT_W;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // a slot is taken when the frame is valid and its tag bit is set
    function automatic logic slot_valid(input logic [15:0] tag, input logic [3:0] idx);
        slot_valid = tag[sau_pkg::TAG_FRAME_VALID] && tag[4'hF - idx];
    endfunction

    // queue level packed into one byte of the levels word
    function automatic logic [7:0] lvl_byte(input logic [LW-1:0] lvl);
        lvl_byte = 8'(lvl);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchroniser: stage one feeds stage two only

    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] prev_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            prev_r <= 3'h0;
        end else if (ce) begin
            sync1_r <= {sdata_in, frame_sync, bit_clk};
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    wire bclk_s = sync2_r[0];
    wire fs_s = sync2_r[1];
    wire sd_s = sync2_r[2];
    wire bclk_rise = ce && bclk_s && !prev_r[0];
    wire bclk_fall = ce && !bclk_s && prev_r[0];
    // frame sync moves with the falling link edge, never in the cycle of a rising one,
    // so it is compared with its level at the previous sampled rising edge
    logic fs_bit_r;
    wire fs_change = fs_s != fs_bit_r;
    wire fs_rise = fs_s && !fs_bit_r;

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [sau_pkg::CTRL_W-1:0] ctrl_r;
    logic [sau_pkg::STAT_W-1:0] status_r;
    logic [sau_pkg::STAT_W-1:0] mask_r;
    logic [sau_pkg::STAT_W-1:0] status_nxt;
    logic [sau_pkg::STAT_W-1:0] stat_set;

    wire tx_en = ctrl_r[sau_pkg::CTRL_TX_EN];
    wire rx_en = ctrl_r[sau_pkg::CTRL_RX_EN];
    wire ac97 = ctrl_r[sau_pkg::CTRL_AC97];
    // dual channel mode
    // two-queue operation only when all three enables are set; otherwise one queue
    wire dual = ctrl_r[sau_pkg::CTRL_DUAL_CHANNEL_ENABLE]
        && ctrl_r[sau_pkg::CTRL_FIRST_FIFO_ENABLE]
        && ctrl_r[sau_pkg::CTRL_SECOND_FIFO_ENABLE];

    wire wr_ctrl = ce && wr_en && (addr == sau_pkg::OFF_CTRL);
    wire wr_status = ce && wr_en && (addr == sau_pkg::OFF_STATUS);
    wire wr_mask = ce && wr_en && (addr == sau_pkg::OFF_MASK);
    wire wr_tx0 = ce && wr_en && (addr == sau_pkg::OFF_TX_FIRST);
    wire wr_tx1 = ce && wr_en && (addr == sau_pkg::OFF_TX_SECOND);
    wire rd_rx0 = ce && rd_en && (addr == sau_pkg::OFF_RX_FIRST);
    wire rd_rx1 = ce && rd_en && (addr == sau_pkg::OFF_RX_SECOND);

    ////////////////////////////////////////////////////////////////////////////////
    // sample queues

    logic [SW-1:0] tx0_head, tx1_head, rx0_head, rx1_head;
    logic tx0_full, tx1_full, rx0_full, rx1_full;
    logic tx0_empty, tx1_empty, rx0_empty, rx1_empty;
    logic [LW-1:0] tx0_lvl, tx1_lvl, rx0_lvl, rx1_lvl;
    logic tx_pop0, tx_pop1, rx_push0, rx_push1;
    logic [SW-1:0] rx_word;

    sample_fifo #(.W(SW), .DEPTH(DEPTH)) u_tx_first (
        .core_clk(core_clk), .rst(rst), .ce(ce),
        .push(wr_tx0), .push_data(wr_data[SW-1:0]), .pop(tx_pop0),
        .head(tx0_head), .full(tx0_full), .empty(tx0_empty), .level(tx0_lvl)
    );
    sample_fifo #(.W(SW), .DEPTH(DEPTH)) u_tx_second (
        .core_clk(core_clk), .rst(rst), .ce(ce),
        .push(wr_tx1), .push_data(wr_data[SW-1:0]), .pop(tx_pop1),
        .head(tx1_head), .full(tx1_full), .empty(tx1_empty), .level(tx1_lvl)
    );
    sample_fifo #(.W(SW), .DEPTH(DEPTH)) u_rx_first (
        .core_clk(core_clk), .rst(rst), .ce(ce),
        .push(rx_push0), .push_data(rx_word), .pop(rd_rx0),
        .head(rx0_head), .full(rx0_full), .empty(rx0_empty), .level(rx0_lvl)
    );
    sample_fifo #(.W(SW), .DEPTH(DEPTH)) u_rx_second (
        .core_clk(core_clk), .rst(rst), .ce(ce),
        .push(rx_push1), .push_data(rx_word), .pop(rd_rx1),
        .head(rx1_head), .full(rx1_full), .empty(rx1_empty), .level(rx1_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // slot timing on sampled link clock edges

    logic [4:0] bit_cnt_r;
    logic [3:0] slot_idx_r;
    logic fin_right_r;
    logic fin_pcm_r;
    logic [SW-1:0] rx_sh_r;
    logic [SW-1:0] tx_sh_r;
    logic [15:0] tag_r;
    logic ign_r;
    logic ign_d_r;
    logic [SW-1:0] last_l_r;
    logic [SW-1:0] last_r_r;
    logic [7:0] half_cnt_r;

    // I2S slots follow the word select level; AC97 slots follow bit counts from sync
    wire [4:0] slot_len = !ac97 ? sau_pkg::I2S_BITS
        : (slot_idx_r == 4'h0) ? sau_pkg::AC97_TAG_BITS : sau_pkg::AC97_DATA_BITS;
    wire slot_start = bclk_rise && (ac97 ? (fs_rise || bit_cnt_r == slot_len) : fs_change);
    wire [3:0] new_idx = fs_rise ? 4'h0 : slot_idx_r + 4'h1;
    wire new_right = ac97 ? (new_idx == sau_pkg::AC97_SLOT_RIGHT) : fs_s;
    wire new_pcm = !ac97 || new_idx == sau_pkg::AC97_SLOT_LEFT
        || new_idx == sau_pkg::AC97_SLOT_RIGHT;
    wire new_tag = ac97 && new_idx == 4'h0;

    // ignore bridging
    // the ignore level may drop for one cycle between frames, so the old value is kept
    wire slot_ignore = ac97 && (ign_r || ign_d_r);
    // ratio check
    // a half period shorter than the crossing needs flags the slot-ignore as unreliable
    wire ratio_bad = (bclk_rise || bclk_fall) && half_cnt_r < sau_pkg::SYNC_MIN_CYCLES;

    ////////////////////////////////////////////////////////////////////////////////
    // receive path

    // receive alignment
    // AC97 keeps the whole 20-bit slot, so a 16-bit sample sits in bits 19..4
    assign rx_word = ac97 ? rx_sh_r : SW'(rx_sh_r[sau_pkg::I2S_WORD_BITS-1:0]);
    wire rx_store = slot_start && rx_en && fin_pcm_r && !slot_ignore;
    // receive steering
    // single queue takes samples in arrival order; dual splits by channel
    wire rx_to_second = dual && fin_right_r;
    assign rx_push0 = rx_store && !rx_to_second;
    assign rx_push1 = rx_store && rx_to_second;
    // overrun drop
    // a dropped sample is not replaced, so later samples can land one channel off
    wire rx_overrun = (rx_push0 && rx0_full) || (rx_push1 && rx1_full);

    ////////////////////////////////////////////////////////////////////////////////
    // transmit path

    wire tx_start = slot_start && tx_en && new_pcm;
    wire use_second = dual && new_right;
    // no slot tracking in single mode: whatever is queued goes out in this slot
    assign tx_pop0 = tx_start && !use_second && !tx0_empty;
    assign tx_pop1 = tx_start && use_second && !tx1_empty;
    wire tx_underrun = tx_start && (use_second ? tx1_empty : tx0_empty);
    // underrun repeat
    // an empty source resends its own previous sample; single mode only has one
    wire [SW-1:0] tx_word = tx_pop0 ? tx0_head : tx_pop1 ? tx1_head
        : use_second ? last_r_r : last_l_r;
    wire [SW-1:0] tx_load = !tx_en ? '0
        : new_tag ? {sau_pkg::TX_TAG, 4'h0}
        : !new_pcm ? '0
        : ac97 ? tx_word : {tx_word[sau_pkg::I2S_WORD_BITS-1:0], 4'h0};

    assign stat_set = {ratio_bad, rx_overrun, tx_underrun};
    // a new event beats a clear in the same cycle
    assign status_nxt = (status_r & ~(wr_status ? wr_data[sau_pkg::STAT_W-1:0] : '0))
        | stat_set;

    ////////////////////////////////////////////////////////////////////////////////
    // read mux, answer registered one cycle after the strobe

    wire [31:0] levels_w = {lvl_byte(rx1_lvl), lvl_byte(rx0_lvl),
        lvl_byte(tx1_lvl), lvl_byte(tx0_lvl)};
    wire [31:0] rd_mux =
        (addr == sau_pkg::OFF_CTRL) ? 32'(ctrl_r) :
        (addr == sau_pkg::OFF_STATUS) ? 32'(status_r) :
        (addr == sau_pkg::OFF_MASK) ? 32'(mask_r) :
        (addr == sau_pkg::OFF_RX_FIRST) ? (rx0_empty ? 32'h0 : 32'(rx0_head)) :
        (addr == sau_pkg::OFF_RX_SECOND) ? (rx1_empty ? 32'h0 : 32'(rx1_head)) :
        (addr == sau_pkg::OFF_LEVELS) ? levels_w : 32'h0;

    // register port state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= sau_pkg::CTRL_RESET;
            mask_r <= sau_pkg::MASK_RESET;
            status_r <= sau_pkg::STAT_RESET;
            rd_data <= 32'h0;
            irq <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_r <= wr_data[sau_pkg::CTRL_W-1:0];
            end
            if (wr_mask) begin
                mask_r <= wr_data[sau_pkg::STAT_W-1:0];
            end
            status_r <= status_nxt;
            rd_data <= rd_en ? rd_mux : 32'h0;
            irq <= |(status_r & mask_r);
        end
    end

    // slot counters and channel of the slot in progress
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bit_cnt_r <= 5'h0;
            slot_idx_r <= 4'h0;
            fin_right_r <= 1'b0;
            fin_pcm_r <= 1'b0;
            fs_bit_r <= 1'b0;
        end else if (bclk_rise) begin
            fs_bit_r <= fs_s;
            bit_cnt_r <= slot_start ? 5'h1 : bit_cnt_r + 5'h1;
            if (slot_start) begin
                slot_idx_r <= new_idx;
                fin_right_r <= new_right;
                fin_pcm_r <= new_pcm;
            end
        end
    end

    // receive shifter and AC97 tag capture
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_sh_r <= '0;
            tag_r <= 16'h0;
            ign_r <= 1'b0;
            ign_d_r <= 1'b0;
        end else if (ce) begin
            ign_d_r <= ign_r;
            if (bclk_rise) begin
                rx_sh_r <= slot_start ? SW'(sd_s) : {rx_sh_r[SW-2:0], sd_s};
            end
            if (slot_start && slot_idx_r == 4'h0 && ac97) begin
                tag_r <= rx_sh_r[15:0];
            end
            if (slot_start) begin
                ign_r <= !slot_valid(tag_r, new_idx);
            end
        end
    end

    // transmit shifter: load at slot start, shift on later rising edges
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_sh_r <= '0;
            sdata_out <= 1'b0;
        end else begin
            if (slot_start) begin
                tx_sh_r <= tx_load;
            end else if (bclk_rise) begin
                tx_sh_r <= {tx_sh_r[SW-2:0], 1'b0};
            end
            // drive on the falling edge so the codec samples a settled bit
            if (bclk_fall) begin
                sdata_out <= tx_sh_r[SW-1];
            end
        end
    end

    // previous sample per source for underrun repeat
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            last_l_r <= '0;
            last_r_r <= '0;
        end else begin
            if (tx_pop0) begin
                last_l_r <= tx0_head;
            end
            if (tx_pop1) begin
                last_r_r <= tx1_head;
            end
        end
    end

    // core cycles since the last link clock edge, saturating
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            half_cnt_r <= 8'hFF;
        end else if (ce) begin
            if (bclk_rise || bclk_fall) begin
                half_cnt_r <= 8'h1;
            end else if (half_cnt_r != 8'hFF) begin
                half_cnt_r <= half_cnt_r + 8'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_tx_empty_start;
        tx_start && (use_second ? tx1_empty : tx0_empty);
    endsequence

    property p_rx_align;
        rx_store && ac97 |-> rx_word == rx_sh_r;
    endproperty
    a_rx_align: assert property (p_rx_align) else $error("ac97 sample misaligned");

    property p_ratio_flag;
        ratio_bad |=> status_r[sau_pkg::STAT_CLOCK_RATIO];
    endproperty
    a_ratio_flag: assert property (p_ratio_flag) else $error("ratio flag missing");

    property p_single_one_queue;
        !dual |-> !rx_push1 && !tx_pop1;
    endproperty
    a_single_one_queue: assert property (p_single_one_queue) else $error("second queue used");

    property p_single_repeat;
        s_tx_empty_start ##0 !dual |=> $stable(last_l_r) ##0 (tx_sh_r == $past(tx_load));
    endproperty
    a_single_repeat: assert property (p_single_repeat) else $error("repeat lost");

    property p_dual_source;
        tx_start && dual && !new_right && !tx0_empty |=> last_l_r == $past(tx0_head);
    endproperty
    a_dual_source: assert property (p_dual_source) else $error("left from wrong queue");

    property p_dual_repeat;
        tx_start && dual && new_right && tx1_empty |=> $stable(last_r_r)[*2];
    endproperty
    a_dual_repeat: assert property (p_dual_repeat) else $error("right repeat broken");

    property p_dual_rx;
        rx_store && dual |-> (rx_push1 == fin_right_r) && (rx_push0 == !fin_right_r);
    endproperty
    a_dual_rx: assert property (p_dual_rx) else $error("rx channel misrouted");

    property p_underrun_flag;
        s_tx_empty_start |=> status_r[sau_pkg::STAT_TX_UNDERRUN];
    endproperty
    a_underrun_flag: assert property (p_underrun_flag) else $error("underrun unflagged");

    property p_irq;
        ce && |(status_r & mask_r) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");
endmodule

`default_nettype wire

//--- tb.sv
// testbench: register-port scenarios for the serial audio unit against the codec model
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic core_clk;
    logic rst;
    logic ce;
    logic [7:0] addr;
    logic [31:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_data;
    logic bit_clk;
    logic frame_sync;
    logic sdata_in;
    logic sdata_out;
    logic irq;
    logic run;
    logic [8:0] len;
    logic [255:0] fb;
    logic [255:0] fs;
    logic [255:0] ob;
    logic [31:0] d;
    int failures;
    int n_compared;

    serial_audio_unit #(.DEPTH(8)) dut (.core_clk(core_clk), .rst(rst), .ce(ce), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .bit_clk(bit_clk),
        .frame_sync(frame_sync), .sdata_in(sdata_in), .sdata_out(sdata_out), .irq(irq));
    codec_model codec (.run(run), .len(len), .fb(fb), .fs(fs), .sdata_out(sdata_out),
        .bit_clk(bit_clk), .frame_sync(frame_sync), .sdata_in(sdata_in), .ob(ob));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, watchdog and end-of-test report
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #600000;
        failures++;
        finish_test();
    end

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // register port tasks; one idle cycle between accesses keeps strobes single-driven
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // frame builders and transmit word extraction
    task automatic i2s_frame(input logic [15:0] l, input logic [15:0] r);
        len = 9'd32;
        fb = '0;
        fs = '0;
        for (int i = 0; i < 16; i++) begin
            fb[i] = l[15-i];
            fb[16+i] = r[15-i];
            fs[16+i] = 1'b1;
        end
    endtask
    task automatic ac97_frame(input logic [15:0] l, input logic [15:0] r);
        len = 9'd256;
        fb = '0;
        fs = '0;
        for (int i = 0; i < 16; i++) begin
            fb[i] = sau_pkg::TX_TAG[15-i];
            fs[i] = 1'b1;
            fb[56+i] = l[15-i];
            fb[76+i] = r[15-i];
        end
    endtask
    function automatic logic [31:0] tx_word(input logic side);
        logic [31:0] w;
        w = '0;
        for (int i = 0; i < 16; i++) w[i] = side ? ob[(32-i)%32] : ob[16-i];
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        run = 1'b0;
        failures = 0;
        n_compared = 0;
        i2s_frame(16'hC3A5, 16'h3C5A);
        wait_cyc(8);
        rst <= 1'b0;
        run <= 1'b1;
        rchk(sau_pkg::OFF_CTRL, 32'h0);
        rchk(sau_pkg::OFF_STATUS, 32'h0);
        rchk(sau_pkg::OFF_MASK, 32'h0);
        rchk(8'h20, 32'h0);
        rchk(sau_pkg::OFF_RX_FIRST, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // strobes ignored while the clock enable is low
        ce <= 1'b0;
        wr(sau_pkg::OFF_CTRL, 32'h1);
        ce <= 1'b1;
        rchk(sau_pkg::OFF_CTRL, 32'h0);
        // dual transmit: per-channel queues and per-channel repeat on underrun
        wr(sau_pkg::OFF_TX_FIRST, 32'h0000A5A1);
        wr(sau_pkg::OFF_TX_FIRST, 32'h0000A5A2);
        wr(sau_pkg::OFF_TX_SECOND, 32'h00005A51);
        wr(sau_pkg::OFF_TX_SECOND, 32'h00005A52);
        rchk(sau_pkg::OFF_LEVELS, 32'h00000202);
        wr(sau_pkg::OFF_MASK, 32'h1);
        // software selects dual mode with all three bits
        wr(sau_pkg::OFF_CTRL, 32'h39);
        wait_cyc(2400);
        chk(tx_word(1'b0), 32'h0000A5A2);
        chk(tx_word(1'b1), 32'h00005A52);
        rchk(sau_pkg::OFF_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(sau_pkg::OFF_CTRL, 32'h0);
        wr(sau_pkg::OFF_STATUS, 32'h7);
        rchk(sau_pkg::OFF_STATUS, 32'h0);
        wait_cyc(2);
        chk({31'h0, irq}, 32'h0);
        // single transmit underrun repeats the last sample on both slots
        wr(sau_pkg::OFF_TX_FIRST, 32'h00001111);
        wr(sau_pkg::OFF_TX_FIRST, 32'h00002222);
        wr(sau_pkg::OFF_CTRL, 32'h1);
        wait_cyc(2400);
        chk(tx_word(1'b0), 32'h00002222);
        chk(tx_word(1'b1), 32'h00002222);
        wr(sau_pkg::OFF_CTRL, 32'h0);
        wr(sau_pkg::OFF_STATUS, 32'h7);
        // dual receive; the first entry may hold a partial slot and is skipped
        wr(sau_pkg::OFF_CTRL, 32'h3A);
        wait_cyc(1600);
        wr(sau_pkg::OFF_CTRL, 32'h0);
        rd(sau_pkg::OFF_RX_FIRST, d);
        rchk(sau_pkg::OFF_RX_FIRST, 32'h0000C3A5);
        rd(sau_pkg::OFF_RX_SECOND, d);
        rchk(sau_pkg::OFF_RX_SECOND, 32'h00003C5A);
        // single receive into a full queue: overrun, masked interrupt, alternation
        // drain both queues; reads of an empty queue return zero and pop nothing
        repeat (8) rd(sau_pkg::OFF_RX_FIRST, d);
        repeat (8) rd(sau_pkg::OFF_RX_SECOND, d);
        wr(sau_pkg::OFF_MASK, 32'h2);
        wr(sau_pkg::OFF_CTRL, 32'h2);
        wait_cyc(3200);
        rchk(sau_pkg::OFF_STATUS, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(sau_pkg::OFF_CTRL, 32'h0);
        rchk(sau_pkg::OFF_LEVELS, 32'h00080000);
        rd(sau_pkg::OFF_RX_FIRST, d);
        rd(sau_pkg::OFF_RX_FIRST, d);
        rchk(sau_pkg::OFF_RX_FIRST, d ^ 32'h0000FFFF);
        wr(sau_pkg::OFF_STATUS, 32'h7);
        // AC97 dual receive with the transmitter kept off; stale I2S samples drained first
        repeat (8) rd(sau_pkg::OFF_RX_FIRST, d);
        ac97_frame(16'hBEEF, 16'h1357);
        wr(sau_pkg::OFF_CTRL, 32'h3E);
        wait_cyc(10000);
        wr(sau_pkg::OFF_CTRL, 32'h0);
        rd(sau_pkg::OFF_RX_FIRST, d);
        rchk(sau_pkg::OFF_RX_FIRST, 32'h000BEEF0);
        rd(sau_pkg::OFF_RX_SECOND, d);
        rchk(sau_pkg::OFF_RX_SECOND, 32'h00013570);
        finish_test();
    end
endmodule
`default_nettype wire
